/* logic/alt_regs.svh */
// Register offsets, fields, reset values and counts of the analog level trigger
// Assumes a register port with 8-bit addresses and 32-bit data
`ifndef ALT_REGS_SVH
`define ALT_REGS_SVH
`define ALT_CTRL_OFS 8'h00
`define ALT_LOW_OFS 8'h04
`define ALT_HIGH_OFS 8'h08
`define ALT_STAT_OFS 8'h0C
`define ALT_IRQ_OFS 8'h10
`define ALT_MASK_OFS 8'h14
`define ALT_SWTRIG_OFS 8'h18
`define ALT_CTRL_MODE_LSB 0
`define ALT_CTRL_SRC_BIT 4
`define ALT_CTRL_EXT_EN_BIT 5
`define ALT_CTRL_RST 32'h00000000
`define ALT_THR_RST 16'h0000
`define ALT_IRQ_RISE_BIT 0
`define ALT_IRQ_START_BIT 1
`define ALT_DIRECT_STEPS 256
`define ALT_POST_STEPS_12 256
`define ALT_POST_STEPS_16 4096
`endif

/* logic/alt_pkg.sv */
// Types of the analog level trigger
// Assumes alt_regs.svh is on the include path
package alt_pkg;
  typedef enum logic [2:0] {
    ALT_BELOW_LOW = 3'h0,
    ALT_ABOVE_HIGH = 3'h1,
    ALT_INSIDE = 3'h2,
    ALT_HYST_HIGH = 3'h3,
    ALT_HYST_LOW = 3'h4
  } alt_mode_t;
  typedef enum logic [2:0] {
    ALT_ST_IDLE = 3'b001,
    ALT_ST_ARMED = 3'b010,
    ALT_ST_FIRED = 3'b100
  } alt_state_t;
endpackage

/* logic/alt_compare.sv */
// Magnitude comparison of the level against both thresholds
// Assumes signed levels of one width, all synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module alt_compare #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic signed [W-1:0] level,
  input wire logic signed [W-1:0] low_thr,
  input wire logic signed [W-1:0] high_thr,
  output logic below_q,
  output logic above_q
);
  logic below_d;
  logic above_d;
  always_comb begin
    below_d = level < low_thr;
    above_d = level > high_thr;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      below_q <= 1'b0;
      above_q <= 1'b0;
    end else begin
      below_q <= below_d;
      above_q <= above_d;
    end
  end
endmodule
`default_nettype wire

/* logic/alt_trigger.sv */
// Analog level trigger: source select, five modes, start sources, irq
// Assumes synchronous digitised levels and a one-cycle-latency register port
//
// Function
// - Five comparison modes; lower and upper thresholds written separately
// - Below-low: trigger while level under lower threshold
// - Above-high: trigger while level over upper threshold
// - Inside-region: trigger while level lies between both thresholds
// - High hysteresis: fire above upper threshold, rearm below lower
// - Low hysteresis: fire below lower threshold, rearm above upper
// - Source bit picks direct pin level or post-gain amplifier level
// - Direct source thresholds span plus-minus ten volts in fixed steps
// - Post-gain thresholds cover channel full scale in 256 or 4096 steps
// - Result is an internal digital trigger for all timing sections
// - Software trigger and external digital trigger also start acquisition
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "alt_regs.svh"
module alt_trigger import alt_pkg::*; #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  input wire logic signed [W-1:0] direct_trigger_input_pin,
  input wire logic signed [W-1:0] programmable_gain_amplifier,
  input wire logic ext_trigger,
  output logic trig_q,
  output logic trig_rise_q,
  output logic start_q,
  output logic irq_q
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (W != 12 && W != 16) begin : g_bad_w
    $error("alt_trigger: W must be 12 or 16");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] mode_q, mode_d;
  logic src_q, src_d;
  logic ext_en_q, ext_en_d;
  logic signed [W-1:0] low_q, low_d, high_q, high_d;
  logic [2:0] written_q, written_d;
  logic [1:0] irq_stat_q, irq_stat_d, mask_q, mask_d;
  logic [31:0] rdata_d;
  logic sw_start;
  logic ready;
  logic [1:0] ev;

  always_comb begin
    mode_d = mode_q;
    src_d = src_q;
    ext_en_d = ext_en_q;
    low_d = low_q;
    high_d = high_q;
    written_d = written_q;
    sw_start = 1'b0;
    irq_stat_d = irq_stat_q;
    if (wr) begin
      case (addr)
        `ALT_CTRL_OFS: begin
          mode_d = wdata[`ALT_CTRL_MODE_LSB +: 3];
          src_d = wdata[`ALT_CTRL_SRC_BIT];
          ext_en_d = wdata[`ALT_CTRL_EXT_EN_BIT];
          written_d[0] = 1'b1;
        end
        `ALT_LOW_OFS: begin
          low_d = wdata[W-1:0];
          written_d[1] = 1'b1;
        end
        `ALT_HIGH_OFS: begin
          high_d = wdata[W-1:0];
          written_d[2] = 1'b1;
        end
        `ALT_IRQ_OFS: irq_stat_d = irq_stat_q & ~wdata[1:0];
        `ALT_MASK_OFS: begin
        end
        `ALT_SWTRIG_OFS: sw_start = wdata[0];
        default: begin
        end
      endcase
    end
    irq_stat_d = irq_stat_d | ev;
    mask_d = (wr && addr == `ALT_MASK_OFS) ? wdata[1:0] : mask_q;
  end

  assign ready = written_q[0] & written_q[1] & written_q[2];

  // ****************************************
  // Comparison
  // ****************************************
  logic signed [W-1:0] level;
  logic below, above;
  assign level = src_q ? programmable_gain_amplifier : direct_trigger_input_pin;

  // Thresholds use the full level code; coarser steps are software scaling
  alt_compare #(.W(W)) u_cmp (
    .mclk(mclk),
    .rst(rst),
    .level(level),
    .low_thr(low_q),
    .high_thr(high_q),
    .below_q(below),
    .above_q(above)
  );

  // ****************************************
  // Trigger state
  // ****************************************
  alt_state_t st_q, st_d;
  logic trig_d, trig_rise_d, start_d, irq_d;
  logic ext_q, ext_d;

  always_comb begin
    st_d = st_q;
    trig_d = 1'b0;
    case (st_q)
      ALT_ST_IDLE: if (ready) st_d = ALT_ST_ARMED;
      ALT_ST_ARMED: begin
        case (mode_q)
          ALT_BELOW_LOW: trig_d = below;
          ALT_ABOVE_HIGH: trig_d = above;
          ALT_INSIDE: trig_d = !below && !above;
          ALT_HYST_HIGH: if (above) st_d = ALT_ST_FIRED;
          ALT_HYST_LOW: if (below) st_d = ALT_ST_FIRED;
          default: trig_d = 1'b0;
        endcase
        trig_d = trig_d || st_d == ALT_ST_FIRED;
      end
      ALT_ST_FIRED: begin
        trig_d = 1'b1;
        if (mode_q == ALT_HYST_HIGH && below) st_d = ALT_ST_ARMED;
        else if (mode_q == ALT_HYST_LOW && above) st_d = ALT_ST_ARMED;
        else if (mode_q != ALT_HYST_HIGH && mode_q != ALT_HYST_LOW) st_d = ALT_ST_ARMED;
      end
      default: st_d = ALT_ST_IDLE;
    endcase
    if (!ready) begin
      st_d = ALT_ST_IDLE;
      trig_d = 1'b0;
    end
    trig_rise_d = trig_d && !trig_q;
    ext_d = ext_trigger;
    start_d = trig_rise_d || sw_start || (ext_en_q && ext_trigger && !ext_q);
    ev = {start_q, trig_rise_q};
    irq_d = |(irq_stat_q & mask_q);
  end

  always_comb begin
    rdata_d = 32'h00000000;
    if (rd) begin
      case (addr)
        `ALT_CTRL_OFS: rdata_d = {26'h0, ext_en_q, src_q, 1'b0, mode_q};
        `ALT_LOW_OFS: rdata_d = {{(32-W){low_q[W-1]}}, low_q};
        `ALT_HIGH_OFS: rdata_d = {{(32-W){high_q[W-1]}}, high_q};
        `ALT_STAT_OFS: rdata_d = {28'h0, ready, below, above, trig_q};
        `ALT_IRQ_OFS: rdata_d = {30'h0, irq_stat_q};
        `ALT_MASK_OFS: rdata_d = {30'h0, mask_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= 3'h0;
      src_q <= 1'b0;
      ext_en_q <= 1'b0;
      low_q <= '0;
      high_q <= '0;
      written_q <= 3'h0;
      irq_stat_q <= 2'h0;
      mask_q <= 2'h0;
      rdata_q <= 32'h00000000;
      st_q <= ALT_ST_IDLE;
      trig_q <= 1'b0;
      trig_rise_q <= 1'b0;
      start_q <= 1'b0;
      irq_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      src_q <= src_d;
      ext_en_q <= ext_en_d;
      low_q <= low_d;
      high_q <= high_d;
      written_q <= written_d;
      irq_stat_q <= irq_stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      trig_q <= trig_d;
      trig_rise_q <= trig_rise_d;
      start_q <= start_d;
      irq_q <= irq_d;
      ext_q <= ext_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_below;
    @(posedge mclk) disable iff (rst)
      (st_q == ALT_ST_ARMED && ready && mode_q == ALT_BELOW_LOW) |=> trig_q == $past(below);
  endproperty
  a_below: assert property (p_below) else $error("below-low trigger wrong");
  property p_above;
    @(posedge mclk) disable iff (rst)
      (st_q == ALT_ST_ARMED && ready && mode_q == ALT_ABOVE_HIGH) |=> trig_q == $past(above);
  endproperty
  a_above: assert property (p_above) else $error("above-high trigger wrong");
  property p_inside;
    @(posedge mclk) disable iff (rst)
      (st_q == ALT_ST_ARMED && ready && mode_q == ALT_INSIDE && !below && !above) |=> trig_q;
  endproperty
  a_inside: assert property (p_inside) else $error("inside trigger missing");
  property p_hyst_hi;
    @(posedge mclk) disable iff (rst)
      (st_q == ALT_ST_ARMED && ready && mode_q == ALT_HYST_HIGH && above
       && $stable(mode_q) && $stable(written_q)) |=> trig_q && st_q == ALT_ST_FIRED;
  endproperty
  a_hyst_hi: assert property (p_hyst_hi) else $error("high hysteresis not fired");
  property p_hyst_lo;
    @(posedge mclk) disable iff (rst)
      (st_q == ALT_ST_ARMED && ready && mode_q == ALT_HYST_LOW && below) |=> trig_q;
  endproperty
  a_hyst_lo: assert property (p_hyst_lo) else $error("low hysteresis not fired");
  property p_rearm;
    @(posedge mclk) disable iff (rst)
      (st_q == ALT_ST_FIRED && ready && mode_q == ALT_HYST_HIGH && !below && !wr)
      |=> st_q == ALT_ST_FIRED && trig_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("hysteresis rearmed early");
  property p_ready;
    @(posedge mclk) disable iff (rst) !ready |=> !trig_q;
  endproperty
  a_ready: assert property (p_ready) else $error("trigger before configuration");
  property p_rise;
    @(posedge mclk) disable iff (rst) $rose(trig_q) |-> trig_rise_q && start_q;
  endproperty
  a_rise: assert property (p_rise) else $error("rise or start pulse missing");
  property p_sw;
    @(posedge mclk) disable iff (rst) (wr && addr == `ALT_SWTRIG_OFS && wdata[0]) |=> start_q;
  endproperty
  a_sw: assert property (p_sw) else $error("software start missing");
  property p_irq;
    @(posedge mclk) disable iff (rst) |(irq_stat_q & mask_q) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  c_hyst: cover property (@(posedge mclk) disable iff (rst) st_q == ALT_ST_FIRED ##1 st_q == ALT_ST_ARMED);
  c_rise: cover property (@(posedge mclk) disable iff (rst) trig_rise_q);
  c_irq: cover property (@(posedge mclk) disable iff (rst) irq_q);
endmodule
`default_nettype wire

/* dv/alt_timing_model.sv */
// Model of the timing sections that consume the trigger
// Assumes start and update pulses synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module alt_timing_model #(
  parameter int SCANS = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic update,
  output logic [7:0] n_start_q,
  output logic [7:0] n_upd_q,
  output logic [7:0] left_q
);
  always_ff @(posedge mclk) begin
    if (rst) begin
      n_start_q <= 8'h00;
      n_upd_q <= 8'h00;
      left_q <= 8'h00;
    end else begin
      if (start) begin
        n_start_q <= n_start_q + 8'h01;
        left_q <= 8'(SCANS);
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
      if (update) begin
        n_upd_q <= n_upd_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Bench for alt_trigger: register tasks, mode table, starts, irq
// Assumes the design and alt_timing_model compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "alt_regs.svh"
module tb_top import alt_pkg::*; ();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic signed [15:0] lv_d = 16'h0000;
  logic signed [15:0] lv_p = 16'h0000;
  logic [31:0] rdata_q;
  logic trig_q, trig_rise_q, start_q, irq_q;
  logic [7:0] n_start_q, n_upd_q, n;
  logic [3:0] cur = 4'hF;
  int errors = 0;
  int compares = 0;
  always #50 mclk = ~mclk;
  alt_trigger #(.W(16)) alt_trigger_i (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .direct_trigger_input_pin(lv_d), .programmable_gain_amplifier(lv_p),
    .ext_trigger(ext), .trig_q(trig_q), .trig_rise_q(trig_rise_q),
    .start_q(start_q), .irq_q(irq_q));
  alt_timing_model alt_timing_model_i (.mclk(mclk), .rst(rst), .start(start_q),
    .update(trig_rise_q), .n_start_q(n_start_q), .n_upd_q(n_upd_q), .left_q());
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata_q, e);
  endtask
  task automatic step(input logic [2:0] m, input logic s, input logic [15:0] v,
    input logic e);
    if ({s, m} !== cur) begin
      cur = {s, m};
      wreg(`ALT_CTRL_OFS, {27'h0, s, 1'b0, m});
    end
    @(posedge mclk);
    lv_d <= s ? ~v : v;
    lv_p <= s ? v : ~v;
    cyc(4);
    chk({31'h0, trig_q}, {31'h0, e});
  endtask
  task automatic ext_pulse(input logic [7:0] e);
    n = n_start_q;
    @(posedge mclk);
    ext <= 1'b1;
    cyc(4);
    chk({24'h0, n_start_q - n}, {24'h0, e});
    @(posedge mclk);
    ext <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rchk(`ALT_CTRL_OFS, 32'h0);
    rchk(`ALT_STAT_OFS, 32'h0);
    step(ALT_BELOW_LOW, 1'b0, 16'hFE0C, 1'b0);
    wreg(`ALT_LOW_OFS, 32'h0000FF9C);
    step(ALT_BELOW_LOW, 1'b0, 16'hFE0C, 1'b0);
    wreg(`ALT_HIGH_OFS, 32'h00000064);
    step(ALT_BELOW_LOW, 1'b0, 16'hFE0C, 1'b1);
    rchk(`ALT_LOW_OFS, 32'hFFFFFF9C);
    rchk(`ALT_HIGH_OFS, 32'h00000064);
    $display("config test done");
    step(ALT_BELOW_LOW, 1'b0, 16'hFF9C, 1'b0);
    step(ALT_BELOW_LOW, 1'b0, 16'h01F4, 1'b0);
    step(ALT_ABOVE_HIGH, 1'b0, 16'h0065, 1'b1);
    step(ALT_ABOVE_HIGH, 1'b0, 16'h0064, 1'b0);
    step(ALT_ABOVE_HIGH, 1'b0, 16'hFE0C, 1'b0);
    step(ALT_INSIDE, 1'b0, 16'h0000, 1'b1);
    step(ALT_INSIDE, 1'b0, 16'h0064, 1'b1);
    step(ALT_INSIDE, 1'b0, 16'hFF9C, 1'b1);
    step(ALT_INSIDE, 1'b0, 16'h0065, 1'b0);
    step(ALT_INSIDE, 1'b0, 16'hFF9B, 1'b0);
    n = n_upd_q;
    step(ALT_HYST_HIGH, 1'b0, 16'h0065, 1'b1);
    step(ALT_HYST_HIGH, 1'b0, 16'h0000, 1'b1);
    step(ALT_HYST_HIGH, 1'b0, 16'h0065, 1'b1);
    step(ALT_HYST_HIGH, 1'b0, 16'hFF9B, 1'b0);
    step(ALT_HYST_HIGH, 1'b0, 16'h0000, 1'b0);
    chk({24'h0, n_upd_q - n}, 32'h1);
    step(ALT_HYST_LOW, 1'b0, 16'hFF9B, 1'b1);
    step(ALT_HYST_LOW, 1'b0, 16'h0000, 1'b1);
    step(ALT_HYST_LOW, 1'b0, 16'h0065, 1'b0);
    step(ALT_HYST_LOW, 1'b0, 16'h0000, 1'b0);
    step(ALT_ABOVE_HIGH, 1'b1, 16'h0065, 1'b1);
    step(ALT_ABOVE_HIGH, 1'b0, 16'hFF9A, 1'b0);
    $display("mode test done");
    wreg(`ALT_IRQ_OFS, 32'h3);
    wreg(`ALT_MASK_OFS, 32'h0);
    n = n_start_q;
    wreg(`ALT_SWTRIG_OFS, 32'h1);
    cyc(3);
    chk({24'h0, n_start_q - n}, 32'h1);
    chk({31'h0, irq_q}, 32'h0);
    rchk(`ALT_IRQ_OFS, 32'h2);
    wreg(`ALT_MASK_OFS, 32'h2);
    cyc(2);
    chk({31'h0, irq_q}, 32'h1);
    wreg(`ALT_IRQ_OFS, 32'h2);
    cyc(2);
    chk({31'h0, irq_q}, 32'h0);
    ext_pulse(8'h00);
    wreg(`ALT_CTRL_OFS, 32'h21);
    cur = 4'h1;
    ext_pulse(8'h01);
    n = n_start_q;
    step(ALT_ABOVE_HIGH, 1'b0, 16'h0065, 1'b1);
    cyc(2);
    chk({24'h0, n_start_q - n}, 32'h1);
    rchk(`ALT_STAT_OFS, 32'hB);
    rchk(`ALT_IRQ_OFS, 32'h3);
    $display("start test done");
    rchk(8'h1C, 32'h0);
    $display("bus test done");
    print_verdict();
  end
endmodule
`default_nettype wire
